// ==== ppmg_pkg.sv ====
// Package with widths, reset values and encodings for the port pin mux block
package ppmg_pkg;
  localparam int PPMG_P0_W = 4;
  localparam int PPMG_P1_W = 8;
  localparam int PPMG_P2_W = 8;
  localparam int PPMG_P3_W = 6;
  // Port zero serial master pins
  localparam int PPMG_SPI_SCK_BIT = 0;
  localparam int PPMG_SPI_MO_BIT = 1;
  localparam int PPMG_SPI_MI_BIT = 2;
  // Serial port pins
  localparam int PPMG_UART_RX_BIT = 0;
  localparam int PPMG_UART_TX_BIT = 1;
  // Port three interrupt and pulse pins
  localparam int PPMG_INT0_BIT = 2;
  localparam int PPMG_EXTERNAL_INTERRUPT_ONE_BIT = 3;
  localparam int PPMG_PULSE_OUTPUT_TWO_BIT = 4;
  localparam int PPMG_PULSE_OUTPUT_THREE_BIT = 5;
  // Reset values
  localparam logic [7:0] PPMG_DIR_RST = 8'h00;
  localparam logic [7:0] PPMG_DATA_RST = 8'hff;
  // Synchroniser depth
  localparam int PPMG_SYNC_STAGES = 2;
  // Converter pin mode field
  typedef enum logic [1:0] {
    PPMG_AD2_ADC = 2'h0,
    PPMG_AD2_RSSI = 2'h1,
    PPMG_AD2_IF = 2'h2
  } ppmg_ad2_mode_t;
endpackage

// ==== ppmg_sync.sv ====
// Two flip-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/100ps
module ppmg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ==== ppmg_top.sv ====
// Port pin multiplexer and general I/O ports with alternate functions
`timescale 1ns/100ps
module ppmg_top import ppmg_pkg::*; #(
  parameter int P0_W = PPMG_P0_W,
  parameter int P1_W = PPMG_P1_W,
  parameter int P2_W = PPMG_P2_W,
  parameter int P3_W = PPMG_P3_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ext_reset_n_in,
  input wire logic por_enable_in,
  input wire logic por_event_in,
  input wire logic flash_program_enable_n_in,
  // Register write strobes and data from the core
  input wire logic port_zero_direction_we_in,
  input wire logic port_one_direction_we_in,
  input wire logic port_two_direction_we_in,
  input wire logic port_three_direction_we_in,
  input wire logic port_zero_data_we_in,
  input wire logic port_one_data_we_in,
  input wire logic port_two_data_we_in,
  input wire logic port_three_data_we_in,
  input wire logic [7:0] reg_wdata_in,
  // Alternate function controls
  input wire logic serial_master_enable_in,
  input wire logic spi_sck_in,
  input wire logic spi_mosi_in,
  input wire logic uart_zero_enable_in,
  input wire logic uart_zero_transmit_in,
  input wire logic uart_one_enable_in,
  input wire logic uart_one_transmit_in,
  input wire logic pwm_two_enable_in,
  input wire logic pulse_output_two_in,
  input wire logic pwm_three_enable_in,
  input wire logic pulse_output_three_in,
  input wire logic [1:0] interrupt_enable_reg_in,
  input wire logic [1:0] int_edge_mode_in,
  input wire logic [1:0] int_clear_in,
  input wire logic [1:0] rf_front_end_config_in,
  // Pins
  input wire logic [P0_W-1:0] port_zero_pin_in,
  input wire logic [P1_W-1:0] port_one_pin_in,
  input wire logic [P2_W-1:0] port_two_pin_in,
  input wire logic [P3_W-1:0] port_three_pin_in,
  output logic [P0_W-1:0] port_zero_pin_out,
  output logic [P0_W-1:0] port_zero_pin_oe_out,
  output logic [P1_W-1:0] port_one_pin_out,
  output logic [P1_W-1:0] port_one_pin_oe_out,
  output logic [P2_W-1:0] port_two_pin_out,
  output logic [P2_W-1:0] port_two_pin_oe_out,
  output logic [P3_W-1:0] port_three_pin_out,
  output logic [P3_W-1:0] port_three_pin_oe_out,
  // Read-back and peripheral inputs
  output logic [P0_W-1:0] port_zero_data_out,
  output logic [P1_W-1:0] port_one_data_out,
  output logic [P2_W-1:0] port_two_data_out,
  output logic [P3_W-1:0] port_three_data_out,
  output logic spi_miso_out,
  output logic uart_zero_receive_out,
  output logic uart_one_receive_out,
  output logic [1:0] ext_int_req_out,
  output logic flash_programming_out,
  output logic por_reset_out,
  output logic sys_reset_n_out,
  output logic [1:0] ad2_mode_out
);
  localparam int PIN_W = P0_W + P1_W + P2_W + P3_W;
  localparam int IN_W = PIN_W + 4;
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] syn_in;
  logic [P0_W-1:0] p0_pin;
  logic [P1_W-1:0] p1_pin;
  logic [P2_W-1:0] p2_pin;
  logic [P3_W-1:0] p3_pin;
  logic rst_pin_s;
  logic flash_program_enable_n_n_s;
  logic por_en_s;
  logic por_evt_s;
  // Every pin and strap passes two flip-flops; reset, program and interrupt pins idle high
  // so the edge detector sees no false falling edge as reset ends
  // reset synchronised
  assign raw_in = {ext_reset_n_in, flash_program_enable_n_in, por_enable_in, por_event_in,
                   port_three_pin_in, port_two_pin_in, port_one_pin_in, port_zero_pin_in};
  ppmg_sync #(
    .WIDTH(IN_W),
    .RST_VAL((IN_W'(3) << (IN_W-2)) | (IN_W'(3) << (PIN_W-P3_W+PPMG_INT0_BIT)))
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .async_in(raw_in),
    .sync_out(syn_in)
  );
  assign p0_pin = syn_in[P0_W-1:0];
  assign p1_pin = syn_in[P0_W+P1_W-1:P0_W];
  assign p2_pin = syn_in[P0_W+P1_W+P2_W-1:P0_W+P1_W];
  assign p3_pin = syn_in[PIN_W-1:P0_W+P1_W+P2_W];
  assign por_evt_s = syn_in[PIN_W];
  assign por_en_s = syn_in[PIN_W+1];
  assign flash_program_enable_n_n_s = syn_in[PIN_W+2];
  assign rst_pin_s = syn_in[PIN_W+3];

  // Direction and data registers
  logic [P0_W-1:0] dir0_q, dir0_d, dat0_q, dat0_d;
  logic [P1_W-1:0] dir1_q, dir1_d, dat1_q, dat1_d;
  logic [P2_W-1:0] dir2_q, dir2_d, dat2_q, dat2_d;
  logic [P3_W-1:0] dir3_q, dir3_d, dat3_q, dat3_d;

  always_comb begin
    dir0_d = port_zero_direction_we_in ? reg_wdata_in[P0_W-1:0] : dir0_q;
    dir1_d = port_one_direction_we_in ? reg_wdata_in[P1_W-1:0] : dir1_q;
    dir2_d = port_two_direction_we_in ? reg_wdata_in[P2_W-1:0] : dir2_q;
    dir3_d = port_three_direction_we_in ? reg_wdata_in[P3_W-1:0] : dir3_q;
    dat0_d = port_zero_data_we_in ? reg_wdata_in[P0_W-1:0] : dat0_q;
    dat1_d = port_one_data_we_in ? reg_wdata_in[P1_W-1:0] : dat1_q;
    dat2_d = port_two_data_we_in ? reg_wdata_in[P2_W-1:0] : dat2_q;
    dat3_d = port_three_data_we_in ? reg_wdata_in[P3_W-1:0] : dat3_q;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      dir0_q <= PPMG_DIR_RST[P0_W-1:0];
      dir1_q <= PPMG_DIR_RST[P1_W-1:0];
      dir2_q <= PPMG_DIR_RST[P2_W-1:0];
      dir3_q <= PPMG_DIR_RST[P3_W-1:0];
      dat0_q <= PPMG_DATA_RST[P0_W-1:0];
      dat1_q <= PPMG_DATA_RST[P1_W-1:0];
      dat2_q <= PPMG_DATA_RST[P2_W-1:0];
      dat3_q <= PPMG_DATA_RST[P3_W-1:0];
    end else begin
      dir0_q <= dir0_d;
      dir1_q <= dir1_d;
      dir2_q <= dir2_d;
      dir3_q <= dir3_d;
      dat0_q <= dat0_d;
      dat1_q <= dat1_d;
      dat2_q <= dat2_d;
      dat3_q <= dat3_d;
    end
  end

  // Pin drive computation with alternate-function overrides
  logic [P0_W-1:0] p0_o_d, p0_oe_d, p0_o_q, p0_oe_q;
  logic [P1_W-1:0] p1_o_q, p1_oe_q;
  logic [P2_W-1:0] p2_o_d, p2_oe_d, p2_o_q, p2_oe_q;
  logic [P3_W-1:0] p3_o_d, p3_oe_d, p3_o_q, p3_oe_q;
  logic spi_own, flash_program_enable_n_own;

  // Programmer owns the serial pins; the core master then stays off them
  // program enable
  assign flash_program_enable_n_own = !flash_program_enable_n_n_s;
  assign spi_own = serial_master_enable_in && !flash_program_enable_n_own;

  always_comb begin
    p0_o_d = dat0_q;
    p0_oe_d = dir0_q;
    if (spi_own) begin
      p0_o_d[PPMG_SPI_SCK_BIT] = spi_sck_in;
      p0_o_d[PPMG_SPI_MO_BIT] = spi_mosi_in;
      p0_o_d[PPMG_SPI_MI_BIT] = 1'b0;
      p0_oe_d[PPMG_SPI_MO_BIT] = 1'b1;
      p0_oe_d[PPMG_SPI_MI_BIT] = 1'b0;
      p0_oe_d[PPMG_SPI_SCK_BIT] = 1'b1;
    end else if (flash_program_enable_n_own) begin
      // Clock and data in come from the programmer; released to input
      p0_oe_d[PPMG_SPI_SCK_BIT] = 1'b0;
      p0_oe_d[PPMG_SPI_MO_BIT] = 1'b0;
      p0_oe_d[PPMG_SPI_MI_BIT] = 1'b0;
    end
    p2_o_d = dat2_q;
    p2_oe_d = dir2_q;
    if (uart_one_enable_in) begin
      p2_oe_d[PPMG_UART_RX_BIT] = 1'b0;
      p2_o_d[PPMG_UART_TX_BIT] = uart_one_transmit_in;
      p2_oe_d[PPMG_UART_TX_BIT] = 1'b1;
    end
    p3_o_d = dat3_q;
    p3_oe_d = dir3_q;
    if (uart_zero_enable_in) begin
      p3_oe_d[PPMG_UART_RX_BIT] = 1'b0;
      p3_o_d[PPMG_UART_TX_BIT] = uart_zero_transmit_in;
      p3_oe_d[PPMG_UART_TX_BIT] = 1'b1;
    end
    if (pwm_two_enable_in) begin
      p3_o_d[PPMG_PULSE_OUTPUT_TWO_BIT] = pulse_output_two_in;
      p3_oe_d[PPMG_PULSE_OUTPUT_TWO_BIT] = 1'b1;
    end
    if (pwm_three_enable_in) begin
      p3_o_d[PPMG_PULSE_OUTPUT_THREE_BIT] = pulse_output_three_in;
      p3_oe_d[PPMG_PULSE_OUTPUT_THREE_BIT] = 1'b1;
    end
  end

  // Pin outputs registered so pins never glitch on mux changes
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      p0_o_q <= '0;
      p0_oe_q <= '0;
      p1_o_q <= '0;
      p1_oe_q <= '0;
      p2_o_q <= '0;
      p2_oe_q <= '0;
      p3_o_q <= '0;
      p3_oe_q <= '0;
    end else begin
      p0_o_q <= p0_o_d;
      p0_oe_q <= p0_oe_d;
      p1_o_q <= dat1_q;
      p1_oe_q <= dir1_q;
      p2_o_q <= p2_o_d;
      p2_oe_q <= p2_oe_d;
      p3_o_q <= p3_o_d;
      p3_oe_q <= p3_oe_d;
    end
  end

  // Read-back and peripheral inputs, plus interrupt detection state
  logic [P0_W-1:0] rd0_q;
  logic [P1_W-1:0] rd1_q;
  logic [P2_W-1:0] rd2_q;
  logic [P3_W-1:0] rd3_q;
  logic miso_q, rx0_q, rx1_q, flash_program_enable_n_q;
  logic [1:0] int_lvl, int_prev_q, int_pend_q, int_pend_d, int_req_d, int_req_q;

  assign int_lvl = {p3_pin[PPMG_EXTERNAL_INTERRUPT_ONE_BIT], p3_pin[PPMG_INT0_BIT]};

  // Pending edge sets win over a clear in the same cycle
  // level or edge
  always_comb begin
    int_pend_d = (int_pend_q & ~int_clear_in) | (int_prev_q & ~int_lvl & int_edge_mode_in);
    // Interrupt inputs are active low, as usual for this core family
    // gated by enable
    int_req_d = interrupt_enable_reg_in & ((int_edge_mode_in & int_pend_d) | (~int_edge_mode_in & ~int_lvl));
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rd0_q <= '0;
      rd1_q <= '0;
      rd2_q <= '0;
      rd3_q <= '0;
      miso_q <= 1'b0;
      rx0_q <= 1'b1;
      rx1_q <= 1'b1;
      flash_program_enable_n_q <= 1'b0;
      int_prev_q <= 2'h3;
      int_pend_q <= 2'h0;
      int_req_q <= 2'h0;
    end else begin
      rd0_q <= p0_pin;
      rd1_q <= p1_pin;
      rd2_q <= p2_pin;
      rd3_q <= p3_pin;
      miso_q <= p0_pin[PPMG_SPI_MI_BIT];
      rx0_q <= uart_zero_enable_in ? p3_pin[PPMG_UART_RX_BIT] : 1'b1;
      rx1_q <= uart_one_enable_in ? p2_pin[PPMG_UART_RX_BIT] : 1'b1;
      flash_program_enable_n_q <= flash_program_enable_n_own;
      int_prev_q <= int_lvl;
      int_pend_q <= int_pend_d;
      int_req_q <= int_req_d;
    end
  end

  // Reset and power-on reset state
  logic por_q, sysrst_n_q;
  logic [1:0] ad2_q;
  ppmg_ad2_mode_t ad2_sel;

  // converter pin mode, unknown codes fall back to the converter
  always_comb begin
    ad2_sel = PPMG_AD2_ADC;
    unique case (rf_front_end_config_in)
      PPMG_AD2_RSSI: ad2_sel = PPMG_AD2_RSSI;
      PPMG_AD2_IF: ad2_sel = PPMG_AD2_IF;
      default: ad2_sel = PPMG_AD2_ADC;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      por_q <= 1'b0;
      sysrst_n_q <= 1'b0;
      ad2_q <= 2'h0;
    end else begin
      por_q <= por_en_s && por_evt_s;
      sysrst_n_q <= rst_pin_s && !(por_en_s && por_evt_s);
      ad2_q <= ad2_sel;
    end
  end

  assign port_zero_pin_out = p0_o_q;
  assign port_zero_pin_oe_out = p0_oe_q;
  assign port_one_pin_out = p1_o_q;
  assign port_one_pin_oe_out = p1_oe_q;
  assign port_two_pin_out = p2_o_q;
  assign port_two_pin_oe_out = p2_oe_q;
  assign port_three_pin_out = p3_o_q;
  assign port_three_pin_oe_out = p3_oe_q;
  assign port_zero_data_out = rd0_q;
  assign port_one_data_out = rd1_q;
  assign port_two_data_out = rd2_q;
  assign port_three_data_out = rd3_q;
  assign spi_miso_out = miso_q;
  assign uart_zero_receive_out = rx0_q;
  assign uart_one_receive_out = rx1_q;
  assign ext_int_req_out = int_req_q;
  assign flash_programming_out = flash_program_enable_n_q;
  assign por_reset_out = por_q;
  assign sys_reset_n_out = sysrst_n_q;
  assign ad2_mode_out = ad2_q;
endmodule

// ==== ppmg_top_props.sv ====
// Checker of pin ownership, interrupt gating and reset outputs of the port mux
`timescale 1ns/100ps
module ppmg_top_props import ppmg_pkg::*; #(
  parameter int P0_W = PPMG_P0_W,
  parameter int P3_W = PPMG_P3_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic port_zero_direction_we_in,
  input wire logic serial_master_enable_in,
  input wire logic spi_sck_in,
  input wire logic flash_programming_out,
  input wire logic [P0_W-1:0] port_zero_pin_oe_out,
  input wire logic [P0_W-1:0] port_zero_pin_out,
  input wire logic pwm_two_enable_in,
  input wire logic pulse_output_two_in,
  input wire logic uart_zero_enable_in,
  input wire logic uart_zero_transmit_in,
  input wire logic [P3_W-1:0] port_three_pin_oe_out,
  input wire logic [P3_W-1:0] port_three_pin_out,
  input wire logic [1:0] interrupt_enable_reg_in,
  input wire logic [1:0] ext_int_req_out,
  input wire logic por_enable_in,
  input wire logic por_reset_out,
  input wire logic ext_reset_n_in,
  input wire logic sys_reset_n_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Bit three has no alternate, so a direction write always lands on it
  dir_write_a: assert property (port_zero_direction_we_in |-> ##3 port_zero_pin_oe_out[3] == $past(reg_wdata_in[3], 3))
    else $error("direction write not seen on pin enable");
  // Programming output may lag the internal state by one edge, hence two samples
  spi_drive_a: assert property (serial_master_enable_in && !flash_programming_out ##1 !flash_programming_out
    |-> port_zero_pin_oe_out[2:0] == 3'h3 && port_zero_pin_out[0] == $past(spi_sck_in))
    else $error("serial master does not own port zero pins");
  flash_program_enable_n_release_a: assert property (flash_programming_out [*2] |-> port_zero_pin_oe_out[2:0] == 3'h0)
    else $error("port zero pins driven during programming");
  pwm_drive_a: assert property (pwm_two_enable_in |=> port_three_pin_oe_out[4] && port_three_pin_out[4] == $past(pulse_output_two_in))
    else $error("pulse output not on its pin");
  uart_drive_a: assert property (uart_zero_enable_in |=> port_three_pin_oe_out[1:0] == 2'h2
    && port_three_pin_out[1] == $past(uart_zero_transmit_in))
    else $error("uart pins wrongly driven");
  int_gate_a: assert property (!interrupt_enable_reg_in[1] [*3] |-> !ext_int_req_out[1])
    else $error("interrupt request while disabled");
  por_off_a: assert property (!por_enable_in [*5] |-> !por_reset_out)
    else $error("power-on reset active while disabled");
  ext_rst_a: assert property ($fell(ext_reset_n_in) |-> ##[1:4] !sys_reset_n_out)
    else $error("external reset not passed on");
endmodule
bind ppmg_top ppmg_top_props #(.P0_W(P0_W), .P3_W(P3_W)) u_props (.*);

// ==== ppmg_board.sv ====
// Board-side model of one port: external drivers meeting the chip pin drivers
`timescale 1ns/100ps
module ppmg_board #(
  parameter int W = 8
) (
  input wire logic [W-1:0] oe_in,
  input wire logic [W-1:0] out_in,
  input wire logic [W-1:0] drive_in,
  output logic [W-1:0] level_out
);
  // pin level seen
  // Board drivers are weak, so an enabled chip driver always wins
  assign level_out = (oe_in & out_in) | (~oe_in & drive_in);
endmodule

// ==== ppmg_top_tb.sv ====
// Self-checking testbench of the port pin mux with board models on every port
`timescale 1ns/100ps
module ppmg_top_tb import ppmg_pkg::*;;
  logic clk_sys_in = 0, rst_n_in = 0, ext_reset_n_in = 1, por_enable_in = 0, por_event_in = 0;
  logic flash_program_enable_n_in = 1, serial_master_enable_in = 0, spi_sck_in = 0, spi_mosi_in = 0;
  logic uart_zero_enable_in = 0, uart_zero_transmit_in = 0, uart_one_enable_in = 0, uart_one_transmit_in = 0;
  logic pwm_two_enable_in = 0, pulse_output_two_in = 0, pwm_three_enable_in = 0, pulse_output_three_in = 0;
  logic [1:0] interrupt_enable_reg_in = 0, int_edge_mode_in = 0, int_clear_in = 0, rf_front_end_config_in = 0;
  logic [7:0] we = 8'h00, reg_wdata_in = 8'h00;
  logic [7:0] drv[4] = '{default: 8'h00};
  logic [3:0] port_zero_pin_in, port_zero_pin_out, port_zero_pin_oe_out, port_zero_data_out;
  logic [7:0] port_one_pin_in, port_one_pin_out, port_one_pin_oe_out, port_one_data_out;
  logic [7:0] port_two_pin_in, port_two_pin_out, port_two_pin_oe_out, port_two_data_out;
  logic [5:0] port_three_pin_in, port_three_pin_out, port_three_pin_oe_out, port_three_data_out;
  logic spi_miso_out, uart_zero_receive_out, uart_one_receive_out, flash_programming_out;
  logic por_reset_out, sys_reset_n_out;
  logic [1:0] ext_int_req_out, ad2_mode_out;
  int mismatches = 0, n_tests = 0;
  int wid[4] = '{PPMG_P0_W, PPMG_P1_W, PPMG_P2_W, PPMG_P3_W};
  logic [7:0] m;

  ppmg_top DUT (.*, .port_zero_direction_we_in(we[0]), .port_one_direction_we_in(we[1]),
    .port_two_direction_we_in(we[2]), .port_three_direction_we_in(we[3]), .port_zero_data_we_in(we[4]),
    .port_one_data_we_in(we[5]), .port_two_data_we_in(we[6]), .port_three_data_we_in(we[7]));
  // Board on each port, widths as the package gives them
  ppmg_board #(.W(4)) b0 (.oe_in(port_zero_pin_oe_out), .out_in(port_zero_pin_out), .drive_in(drv[0][3:0]),
    .level_out(port_zero_pin_in));
  ppmg_board b1 (.oe_in(port_one_pin_oe_out), .out_in(port_one_pin_out), .drive_in(drv[1]), .level_out(port_one_pin_in));
  ppmg_board b2 (.oe_in(port_two_pin_oe_out), .out_in(port_two_pin_out), .drive_in(drv[2]), .level_out(port_two_pin_in));
  ppmg_board #(.W(6)) b3 (.oe_in(port_three_pin_oe_out), .out_in(port_three_pin_out), .drive_in(drv[3][5:0]),
    .level_out(port_three_pin_in));

  // 125 MHz clock
  always #4 clk_sys_in = ~clk_sys_in;

  // Fetch enable, drive or read-back of a port, zero-extended
  function automatic logic [7:0] obs(input int p, input int k);
    logic [7:0] v[4][3];
    v[0] = '{8'(port_zero_pin_oe_out), 8'(port_zero_pin_out), 8'(port_zero_data_out)};
    v[1] = '{port_one_pin_oe_out, port_one_pin_out, port_one_data_out};
    v[2] = '{port_two_pin_oe_out, port_two_pin_out, port_two_data_out};
    v[3] = '{8'(port_three_pin_oe_out), 8'(port_three_pin_out), 8'(port_three_data_out)};
    return v[p][k];
  endfunction

  // Wait edges, then step past the edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // One-cycle write strobe, spaced so no two writes sit closer than five edges
  task automatic wr(input int idx, input logic [7:0] d);
    @(posedge clk_sys_in);
    we[idx] <= 1'b1;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    we[idx] <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("Counts: %0d compared, %0d mismatched", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    tick(3);
    for (int p = 0; p < 4; p++) chk("reset oe", 8'h00, obs(p, 0));
    chk("reset rx", 8'h03, {6'h00, uart_one_receive_out, uart_zero_receive_out});
    $display("Test reset done");
    // Mixed direction so each port shows driven and sensed bits together
    for (int p = 0; p < 4; p++) begin
      m = 8'((1 << wid[p]) - 1);
      @(posedge clk_sys_in);
      drv[p] <= 8'h5a;
      wr(p, 8'hc3);
      wr(p + 4, 8'h96);
      tick(4);
      chk("dir", 8'hc3 & m, obs(p, 0));
      chk("drive", 8'h82 & m, obs(p, 1) & 8'hc3);
      chk("read", 8'h9a & m, obs(p, 2));
    end
    $display("Test ports done");
    @(posedge clk_sys_in);
    serial_master_enable_in <= 1'b1;
    spi_sck_in <= 1'b1;
    drv[0] <= 8'h04;
    tick(4);
    chk("spi oe", 8'h03, obs(0, 0));
    chk("spi drive", 8'h01, obs(0, 1) & 8'h03);
    chk("miso", 8'h01, 8'(spi_miso_out));
    @(posedge clk_sys_in);
    flash_program_enable_n_in <= 1'b0;
    tick(5);
    chk("flash_program_enable_n oe", 8'h01, {port_zero_pin_oe_out, 3'h0, flash_programming_out});
    @(posedge clk_sys_in);
    flash_program_enable_n_in <= 1'b1;
    serial_master_enable_in <= 1'b0;
    uart_zero_enable_in <= 1'b1;
    uart_one_enable_in <= 1'b1;
    drv[2] <= 8'h00;
    drv[3] <= 8'h0c;
    tick(5);
    chk("uart0 pins", 8'h02, obs(3, 0) & 8'h03);
    chk("uart1 pins", 8'h02, obs(2, 0) & 8'h03);
    chk("uart tx", 8'h00, (obs(3, 1) | obs(2, 1)) & 8'h02);
    chk("uart rx", 8'h00, {6'h00, uart_one_receive_out, uart_zero_receive_out});
    $display("Test alternates done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_in);
      pwm_two_enable_in <= 1'b1;
      pwm_three_enable_in <= 1'b1;
      pulse_output_two_in <= 1'(1 - i);
      pulse_output_three_in <= 1'(i);
      tick(2);
      chk("pwm oe", 8'h30, obs(3, 0) & 8'h30);
      chk("pwm drive", (i == 0) ? 8'h10 : 8'h20, obs(3, 1) & 8'h30);
    end
    $display("Test pwm done");
    // Level mode: only the enabled input may request
    @(posedge clk_sys_in);
    interrupt_enable_reg_in <= 2'h1;
    drv[3] <= 8'h00;
    tick(6);
    chk("level req", 8'h01, 8'(ext_int_req_out));
    @(posedge clk_sys_in);
    drv[3] <= 8'h0c;
    int_edge_mode_in <= 2'h3;
    interrupt_enable_reg_in <= 2'h3;
    tick(6);
    @(posedge clk_sys_in);
    drv[3] <= 8'h00;
    tick(6);
    @(posedge clk_sys_in);
    drv[3] <= 8'h0c;
    tick(6);
    chk("edge held", 8'h03, 8'(ext_int_req_out));
    @(posedge clk_sys_in);
    int_clear_in <= 2'h3;
    @(posedge clk_sys_in);
    int_clear_in <= 2'h0;
    tick(3);
    chk("edge clear", 8'h00, 8'(ext_int_req_out));
    $display("Test interrupts done");
    @(posedge clk_sys_in);
    ext_reset_n_in <= 1'b0;
    tick(5);
    chk("ext reset", 8'h00, 8'(sys_reset_n_out));
    @(posedge clk_sys_in);
    ext_reset_n_in <= 1'b1;
    por_event_in <= 1'b1;
    tick(5);
    chk("por off", 8'h01, {por_reset_out, sys_reset_n_out});
    @(posedge clk_sys_in);
    por_enable_in <= 1'b1;
    tick(5);
    chk("por on", 8'h02, {por_reset_out, sys_reset_n_out});
    $display("Test resets done");
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys_in);
      rf_front_end_config_in <= 2'(c);
      tick(2);
      chk("ad2 mode", (c == 3) ? 8'h00 : 8'(c), 8'(ad2_mode_out));
    end
    $display("Test converter pin done");
    end_of_test();
  end
endmodule
